/* File: logic/mrh_pkg.sv */
// ****************************************************************
// message receive handshake constants
// ****************************************************************
package mrh_pkg;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned PARAM_WORDS = 17;
  localparam int unsigned IDX_W       = 5;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_DEV        = 8'h04;
  localparam logic [7:0] OFS_PROTO      = 8'h08;
  localparam logic [7:0] OFS_CIRCUIT    = 8'h0C;
  localparam logic [7:0] OFS_CHANNEL    = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;
  localparam logic [7:0] OFS_SCAN       = 8'h18;
  localparam logic [7:0] OFS_PARAM_BASE = 8'h40;
  localparam logic [7:0] OFS_PARAM_LAST = 8'h80;

  // field positions
  localparam int unsigned CTRL_EXEC_BIT  = 0;
  localparam int unsigned CTRL_ABORT_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_DONE_BIT  = 1;
  localparam int unsigned STAT_ERR_BIT   = 2;
  localparam int unsigned STAT_DIGIT_LSB = 4;

  // selector codes
  localparam logic [15:0] DEV_MOTION     = 16'h0001;
  localparam logic [15:0] DEV_SERIAL     = 16'h0005;
  localparam logic [15:0] DEV_ETH_OLD    = 16'h0006;
  localparam logic [15:0] DEV_ETH_NEW    = 16'h0010;
  localparam logic [15:0] PROTO_REG      = 16'h0001;
  localparam logic [15:0] PROTO_RAW_WORD = 16'h0002;
  localparam logic [15:0] PROTO_RAW_BYTE = 16'h0003;

  // accepted ranges
  localparam logic [15:0] SEL_MIN         = 16'h0001;
  localparam logic [15:0] CIRC_MAX_SERIAL = 16'h0010;
  localparam logic [15:0] CIRC_MAX_OTHER  = 16'h0008;
  localparam logic [15:0] CH_MAX_MOTION   = 16'h000C;
  localparam logic [15:0] CH_MAX_ETH      = 16'h000A;
  localparam logic [15:0] CH_MAX_SERIAL   = 16'h0001;

  // result word upper and lower bytes and error digits
  localparam logic [7:0] RES_BUSY   = 8'h00;
  localparam logic [7:0] RES_DONE   = 8'h10;
  localparam logic [3:0] RES_ERR_HI = 4'h8;
  localparam logic [7:0] RES_LOW    = 8'h00;
  localparam logic [3:0] ERR_NONE   = 4'h0;
  localparam logic [3:0] ERR_DEV    = 4'h1;
  localparam logic [3:0] ERR_PROTO  = 4'h2;
  localparam logic [3:0] ERR_CIRC   = 4'h3;
  localparam logic [3:0] ERR_CH     = 4'h4;

  localparam logic [4:0]  IDX_RESULT = 5'h00;
  localparam logic [4:0]  IDX_SIZE   = 5'h06;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [15:0] INC_WORD   = 16'h0001;
  localparam logic [15:0] INC_BYTE   = 16'h0002;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_WAIT_CH = 4'b0010,
    ST_RECV    = 4'b0100,
    ST_ABORT   = 4'b1000
  } mrh_state_t;
endpackage : mrh_pkg

/* File: logic/mrh_mem_if.sv */
`timescale 1ns/1ns
// ****************************************************************
// parameter list port
// ****************************************************************
interface mrh_mem_if;
  logic        res_we;
  logic [15:0] res_data;
  logic        size_we;
  logic [15:0] size_data;
  logic        bus_we;
  logic [4:0]  bus_idx;
  logic [15:0] bus_wdata;
  logic [4:0]  rd_idx;
  logic [15:0] rd_data;
  modport ctl (output res_we, res_data, size_we, size_data, bus_we, bus_idx, bus_wdata,
               output rd_idx, input rd_data);
  modport mem (input res_we, res_data, size_we, size_data, bus_we, bus_idx, bus_wdata,
               input rd_idx, output rd_data);
endinterface : mrh_mem_if

/* File: logic/mrh_param_mem.sv */
`timescale 1ns/1ns
// ****************************************************************
// seventeen word parameter list
// ****************************************************************
module mrh_param_mem (
  input  wire logic clk_sys_in,
  input  wire logic nrst_in,
  mrh_mem_if.mem    mem_if
);
  logic [15:0] words [mrh_pkg::PARAM_WORDS];
  logic [15:0] rd_q;
  logic [15:0] next_rd;

  // control writes win over a bus write to the same word
  for (genvar i = 0; i < mrh_pkg::PARAM_WORDS; i++) begin : g_word
    logic [15:0] next_word;
    always_comb begin
      next_word = words[i];
      if (mem_if.bus_we && (mem_if.bus_idx == 5'(i))) begin
        next_word = mem_if.bus_wdata;
      end
      if (mem_if.res_we && (mrh_pkg::IDX_RESULT == 5'(i))) begin
        next_word = mem_if.res_data;
      end
      if (mem_if.size_we && (mrh_pkg::IDX_SIZE == 5'(i))) begin
        next_word = mem_if.size_data;
      end
    end
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
        words[i] <= mrh_pkg::RST_WORD;
      end else begin
        words[i] <= next_word;
      end
    end
  end

  always_comb begin
    next_rd = mrh_pkg::RST_WORD;
    if (32'(mem_if.rd_idx) < mrh_pkg::PARAM_WORDS) begin
      next_rd = words[mem_if.rd_idx];
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_q <= mrh_pkg::RST_WORD;
    end else begin
      rd_q <= next_rd;
    end
  end

  assign mem_if.rd_data = rd_q;
endmodule : mrh_param_mem

/* File: logic/mrh_top.sv */
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
module mrh_top (
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        rx_valid_in,
  input  wire logic [15:0] rx_data_in,
  input  wire logic        rx_last_in,
  input  wire logic        send_busy_in,
  output logic             rx_ready_out,
  output logic             resp_req_out,
  output logic             rx_chan_busy_out,
  output logic             busy_out,
  output logic             complete_out,
  output logic             error_out
);
  // ****************************************************************
  // selection check
  // ****************************************************************
  function automatic logic [3:0] sel_check(input logic [15:0] dev, input logic [15:0] proto,
                                            input logic [15:0] circ, input logic [15:0] ch);
    logic [15:0] circ_max;
    logic [15:0] ch_max;
    circ_max = mrh_pkg::CIRC_MAX_OTHER;
    ch_max   = mrh_pkg::CH_MAX_ETH;
    sel_check = mrh_pkg::ERR_NONE;
    case (dev)
      mrh_pkg::DEV_MOTION:  ch_max = mrh_pkg::CH_MAX_MOTION;
      mrh_pkg::DEV_SERIAL: begin
        circ_max = mrh_pkg::CIRC_MAX_SERIAL;
        ch_max   = mrh_pkg::CH_MAX_SERIAL;
      end
      mrh_pkg::DEV_ETH_OLD, mrh_pkg::DEV_ETH_NEW: ch_max = mrh_pkg::CH_MAX_ETH;
      default: sel_check = mrh_pkg::ERR_DEV;
    endcase
    if (sel_check == mrh_pkg::ERR_NONE) begin
      if (proto < mrh_pkg::PROTO_REG || proto > mrh_pkg::PROTO_RAW_BYTE) begin
        sel_check = mrh_pkg::ERR_PROTO;
      end else if (circ < mrh_pkg::SEL_MIN || circ > circ_max) begin
        sel_check = mrh_pkg::ERR_CIRC;
      end else if (ch < mrh_pkg::SEL_MIN || ch > ch_max) begin
        sel_check = mrh_pkg::ERR_CH;
      end
    end
  endfunction : sel_check

  mrh_mem_if mem_if ();

  mrh_param_mem u_mem (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .mem_if     (mem_if.mem)
  );

  // ****************************************************************
  // avalon slave
  // ****************************************************************
  logic        rd_stage;
  logic        next_rd_stage;
  logic        next_wait;
  logic [31:0] next_rdata;
  logic        exec_bit;
  logic        abort_bit;
  logic [15:0] dev_sel;
  logic [15:0] proto_sel;
  logic [15:0] circ_sel;
  logic [15:0] ch_sel;
  logic        next_exec_bit;
  logic        next_abort_bit;
  logic [15:0] next_dev_sel;
  logic [15:0] next_proto_sel;
  logic [15:0] next_circ_sel;
  logic [15:0] next_ch_sel;
  logic        wr_fire;
  logic        scan_tick;
  logic        in_param;
  logic [7:0]  param_ofs;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [3:0]  err_digit;

  assign param_ofs = avs_address_in - mrh_pkg::OFS_PARAM_BASE;
  assign in_param  = (avs_address_in >= mrh_pkg::OFS_PARAM_BASE) &&
                     (avs_address_in <= mrh_pkg::OFS_PARAM_LAST) && (avs_address_in[1:0] == 2'h0);
  // parameter words merge byte lanes with the registered old word, so they take one extra cycle
  assign wr_fire   = avs_write_in && avs_waitrequest_out && (rd_stage || !in_param);
  assign scan_tick = wr_fire && (avs_address_in == mrh_pkg::OFS_SCAN);
  assign wmask     = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign wval      = avs_writedata_in[15:0];
  assign mem_if.rd_idx    = param_ofs[6:2];
  assign mem_if.bus_idx   = param_ofs[6:2];
  assign mem_if.bus_we    = wr_fire && in_param;
  assign mem_if.bus_wdata = (wval & wmask) | (mem_if.rd_data & ~wmask);

  always_comb begin
    next_wait      = 1'b1;
    next_rd_stage  = 1'b0;
    next_rdata     = avs_readdata_out;
    next_exec_bit  = exec_bit;
    next_abort_bit = abort_bit;
    next_dev_sel   = dev_sel;
    next_proto_sel = proto_sel;
    next_circ_sel  = circ_sel;
    next_ch_sel    = ch_sel;
    if (wr_fire) begin
      next_wait = 1'b0;
      case (avs_address_in)
        mrh_pkg::OFS_CTRL: if (avs_byteenable_in[0]) begin
          next_exec_bit  = avs_writedata_in[mrh_pkg::CTRL_EXEC_BIT];
          next_abort_bit = avs_writedata_in[mrh_pkg::CTRL_ABORT_BIT];
        end
        mrh_pkg::OFS_DEV:     next_dev_sel   = (wval & wmask) | (dev_sel & ~wmask);
        mrh_pkg::OFS_PROTO:   next_proto_sel = (wval & wmask) | (proto_sel & ~wmask);
        mrh_pkg::OFS_CIRCUIT: next_circ_sel  = (wval & wmask) | (circ_sel & ~wmask);
        mrh_pkg::OFS_CHANNEL: next_ch_sel    = (wval & wmask) | (ch_sel & ~wmask);
        default: next_exec_bit = exec_bit;
      endcase
    end else if ((avs_read_in || (avs_write_in && in_param)) &&
                 avs_waitrequest_out && !rd_stage) begin
      next_rd_stage = 1'b1;
    end else if (avs_read_in && rd_stage) begin
      next_wait  = 1'b0;
      next_rdata = 32'h0000_0000;
      if (in_param) begin
        next_rdata[15:0] = mem_if.rd_data;
      end else begin
        case (avs_address_in)
          mrh_pkg::OFS_CTRL: begin
            next_rdata[mrh_pkg::CTRL_EXEC_BIT]  = exec_bit;
            next_rdata[mrh_pkg::CTRL_ABORT_BIT] = abort_bit;
          end
          mrh_pkg::OFS_DEV:     next_rdata[15:0] = dev_sel;
          mrh_pkg::OFS_PROTO:   next_rdata[15:0] = proto_sel;
          mrh_pkg::OFS_CIRCUIT: next_rdata[15:0] = circ_sel;
          mrh_pkg::OFS_CHANNEL: next_rdata[15:0] = ch_sel;
          mrh_pkg::OFS_STATUS: begin
            next_rdata[mrh_pkg::STAT_BUSY_BIT] = busy_out;
            next_rdata[mrh_pkg::STAT_DONE_BIT] = complete_out;
            next_rdata[mrh_pkg::STAT_ERR_BIT]  = error_out;
            next_rdata[mrh_pkg::STAT_DIGIT_LSB +: 4] = err_digit;
          end
          default: next_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
      rd_stage            <= 1'b0;
      exec_bit            <= 1'b0;
      abort_bit           <= 1'b0;
      dev_sel             <= mrh_pkg::RST_WORD;
      proto_sel           <= mrh_pkg::RST_WORD;
      circ_sel            <= mrh_pkg::RST_WORD;
      ch_sel              <= mrh_pkg::RST_WORD;
    end else begin
      avs_waitrequest_out <= next_wait;
      avs_readdata_out    <= next_rdata;
      rd_stage            <= next_rd_stage;
      exec_bit            <= next_exec_bit;
      abort_bit           <= next_abort_bit;
      dev_sel             <= next_dev_sel;
      proto_sel           <= next_proto_sel;
      circ_sel            <= next_circ_sel;
      ch_sel              <= next_ch_sel;
    end
  end

  // ****************************************************************
  // scan driven control
  // ****************************************************************
  mrh_pkg::mrh_state_t state;
  mrh_pkg::mrh_state_t next_state;
  logic        exec_armed;
  logic        abort_armed;
  logic        got_last;
  logic [15:0] dev_q;
  logic [15:0] proto_q;
  logic [15:0] size_cnt;
  logic        next_exec_armed;
  logic        next_abort_armed;
  logic        next_got_last;
  logic [15:0] next_dev_q;
  logic [15:0] next_proto_q;
  logic [15:0] next_size_cnt;
  logic        next_complete;
  logic        next_error;
  logic        next_resp;
  logic [3:0]  next_err_digit;
  logic [3:0]  chk;
  logic        rx_take;

  assign chk     = sel_check(dev_sel, proto_sel, circ_sel, ch_sel);
  assign rx_take = rx_valid_in && rx_ready_out;

  always_comb begin
    next_state         = state;
    next_exec_armed    = exec_armed;
    next_abort_armed   = abort_armed;
    next_got_last      = got_last;
    next_dev_q         = dev_q;
    next_proto_q       = proto_q;
    next_size_cnt      = size_cnt;
    next_complete      = complete_out;
    next_error         = error_out;
    next_resp          = 1'b0;
    next_err_digit     = err_digit;
    mem_if.res_we      = 1'b0;
    mem_if.res_data    = {mrh_pkg::RES_BUSY, mrh_pkg::RES_LOW};
    mem_if.size_we     = 1'b0;
    mem_if.size_data   = size_cnt;
    if (rx_take) begin
      // byte mode counts two bytes per word
      next_size_cnt = size_cnt + ((proto_q == mrh_pkg::PROTO_RAW_BYTE) ?
                      mrh_pkg::INC_BYTE : mrh_pkg::INC_WORD);
      next_got_last = rx_last_in;
    end
    if (scan_tick) begin
      next_complete    = 1'b0;
      next_error       = 1'b0;
      next_exec_armed  = exec_armed | !exec_bit;
      next_abort_armed = abort_armed | !abort_bit;
      case (state)
        mrh_pkg::ST_IDLE: begin
          if (abort_bit && abort_armed) begin
            next_state       = mrh_pkg::ST_ABORT;
            next_abort_armed = 1'b0;
            mem_if.res_we    = 1'b1;
          end else if (exec_bit && exec_armed) begin
            next_exec_armed = 1'b0;
            next_err_digit  = chk;
            mem_if.res_we   = 1'b1;
            if (chk != mrh_pkg::ERR_NONE) begin
              next_error      = 1'b1;
              mem_if.res_data = {mrh_pkg::RES_ERR_HI, chk, mrh_pkg::RES_LOW};
            end else begin
              next_dev_q    = dev_sel;
              next_proto_q  = proto_sel;
              next_size_cnt = mrh_pkg::RST_WORD;
              next_got_last = 1'b0;
              // serial channel may be held by a send
              next_state = (dev_sel == mrh_pkg::DEV_SERIAL && send_busy_in) ?
                           mrh_pkg::ST_WAIT_CH : mrh_pkg::ST_RECV;
            end
          end
        end
        mrh_pkg::ST_WAIT_CH, mrh_pkg::ST_RECV: begin
          if (abort_bit && abort_armed) begin
            next_state       = mrh_pkg::ST_ABORT;
            next_abort_armed = 1'b0;
          end else if (state == mrh_pkg::ST_WAIT_CH) begin
            if (!send_busy_in) begin
              next_state = mrh_pkg::ST_RECV;
            end
          end else if (got_last) begin
            next_state      = mrh_pkg::ST_IDLE;
            next_complete   = 1'b1;
            next_resp       = (proto_q == mrh_pkg::PROTO_REG);
            mem_if.res_we   = 1'b1;
            mem_if.res_data = {mrh_pkg::RES_DONE, mrh_pkg::RES_LOW};
            mem_if.size_we  = 1'b1;
          end
        end
        mrh_pkg::ST_ABORT: begin
          next_state      = mrh_pkg::ST_IDLE;
          next_complete   = 1'b1;
          mem_if.res_we   = 1'b1;
          mem_if.res_data = {mrh_pkg::RES_DONE, mrh_pkg::RES_LOW};
        end
        default: next_state = mrh_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state            <= mrh_pkg::ST_IDLE;
      exec_armed       <= 1'b0;
      abort_armed      <= 1'b0;
      got_last         <= 1'b0;
      dev_q            <= mrh_pkg::RST_WORD;
      proto_q          <= mrh_pkg::RST_WORD;
      size_cnt         <= mrh_pkg::RST_WORD;
      err_digit        <= mrh_pkg::ERR_NONE;
      complete_out     <= 1'b0;
      error_out        <= 1'b0;
      resp_req_out     <= 1'b0;
      busy_out         <= 1'b0;
      rx_ready_out     <= 1'b0;
      rx_chan_busy_out <= 1'b0;
    end else begin
      state            <= next_state;
      exec_armed       <= next_exec_armed;
      abort_armed      <= next_abort_armed;
      got_last         <= next_got_last;
      dev_q            <= next_dev_q;
      proto_q          <= next_proto_q;
      size_cnt         <= next_size_cnt;
      err_digit        <= next_err_digit;
      complete_out     <= next_complete;
      error_out        <= next_error;
      resp_req_out     <= next_resp;
      busy_out         <= (next_state != mrh_pkg::ST_IDLE);
      rx_ready_out     <= (next_state == mrh_pkg::ST_RECV) && !next_got_last;
      rx_chan_busy_out <= (next_state == mrh_pkg::ST_RECV) &&
                          (next_dev_q == mrh_pkg::DEV_SERIAL);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  sequence s_idle_tick;
    (state == mrh_pkg::ST_IDLE) && scan_tick;
  endsequence
  sequence s_start_req;
    s_idle_tick ##0 (exec_bit && exec_armed && !abort_bit);
  endsequence

  property p_start;
    s_start_req ##0 (chk == mrh_pkg::ERR_NONE) |=> busy_out && !error_out;
  endproperty
  a_start: assert property (p_start) else $error("start did not raise busy");
  property p_abort_kill;
    (state == mrh_pkg::ST_RECV) && scan_tick && abort_bit && abort_armed
      |=> (state == mrh_pkg::ST_ABORT) ##0 busy_out;
  endproperty
  a_abort_kill: assert property (p_abort_kill) else $error("abort ignored");
  property p_abort_prio;
    s_idle_tick ##0 (abort_bit && abort_armed && exec_bit)
      |=> (state == mrh_pkg::ST_ABORT) && !error_out;
  endproperty
  a_abort_prio: assert property (p_abort_prio) else $error("execute beat abort");
  property p_raw_noresp;
    resp_req_out |-> (proto_q == mrh_pkg::PROTO_REG) && $past(state) == mrh_pkg::ST_RECV;
  endproperty
  a_raw_noresp: assert property (p_raw_noresp) else $error("raw mode response");
  property p_serial_ch;
    (dev_sel == mrh_pkg::DEV_SERIAL) && (ch_sel != mrh_pkg::CH_MAX_SERIAL)
      |-> chk != mrh_pkg::ERR_NONE;
  endproperty
  a_serial_ch: assert property (p_serial_ch) else $error("serial channel accepted");
  property p_circ_range;
    (circ_sel > mrh_pkg::CIRC_MAX_SERIAL) |-> chk != mrh_pkg::ERR_NONE;
  endproperty
  a_circ_range: assert property (p_circ_range) else $error("circuit accepted");
  property p_chan_share;
    rx_chan_busy_out |-> (state == mrh_pkg::ST_RECV) && !$past(send_busy_in) ||
                         (state == mrh_pkg::ST_RECV) && $past(state) == mrh_pkg::ST_RECV;
  endproperty
  a_chan_share: assert property (p_chan_share) else $error("serial channel shared");
  property p_busy_hold;
    (state != mrh_pkg::ST_IDLE) |-> busy_out && !complete_out;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped");
  property p_done_scan;
    complete_out && !scan_tick |=> complete_out;
  endproperty
  a_done_scan: assert property (p_done_scan) else $error("complete short");
  property p_done_end;
    complete_out && scan_tick |=> !complete_out;
  endproperty
  a_done_end: assert property (p_done_end) else $error("complete long");
  property p_err_scan;
    error_out |-> (scan_tick |=> !error_out) and (!scan_tick |=> error_out);
  endproperty
  a_err_scan: assert property (p_err_scan) else $error("error not one scan");
  property p_result_done;
    $rose(complete_out) |-> $past(mem_if.res_we) && $past(mem_if.res_data[15:8]) == 8'h10;
  endproperty
  a_result_done: assert property (p_result_done) else $error("result not done");
  property p_bad_sel;
    s_start_req ##0 (chk != mrh_pkg::ERR_NONE) |=> error_out && !busy_out ##1 !rx_ready_out;
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("bad selection started");
endmodule : mrh_top

/* File: tb/mrh_link_model.sv */
`timescale 1ns/1ns
// ****
// remote station feeding one message
// ****
module mrh_link_model (
  input  wire logic        clk_sys_in,
  input  wire logic        start_in,
  input  wire logic [7:0]  count_in,
  input  wire logic        slow_in,
  input  wire logic        rx_ready_in,
  output logic             rx_valid_out,
  output logic [15:0]      rx_data_out,
  output logic             rx_last_out
);
  int left = 0;
  initial rx_valid_out = 1'b0;
  initial rx_data_out = 16'h0000;
  assign rx_last_out = rx_valid_out && (left == 1);
  always @(posedge clk_sys_in) begin
    if (start_in) begin
      left <= count_in;
    end else if (rx_valid_out && rx_ready_in) begin
      left <= left - 1;
    end
    // a word stays offered until taken; idle data toggles
    if (rx_valid_out && !rx_ready_in && !start_in) begin
      rx_valid_out <= 1'b1;
    end else begin
      rx_valid_out <= !start_in && (left - (rx_valid_out && rx_ready_in) > 0)
                      && !(slow_in && rx_valid_out);
      rx_data_out  <= ~rx_data_out;
    end
  end
endmodule : mrh_link_model

/* File: tb/mrh_top_tb_top.sv */
`timescale 1ns/1ns
module mrh_top_tb_top;
  logic clk_sys_in = 0, nrst_in = 0, rd = 0, wr = 0, rv, rl, start = 0, slow = 0, sb = 0;
  logic [7:0] adr = 8'h00, cnt = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rdat, q;
  logic [15:0] rxd;
  logic wait_n, ready, resp, chb, busy, cmpl, err;
  int num_errors = 0, n_compared = 0, resp_cnt = 0;
  mrh_top i_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_n), .rx_valid_in(rv),
    .rx_data_in(rxd), .rx_last_in(rl), .send_busy_in(sb), .rx_ready_out(ready),
    .resp_req_out(resp), .rx_chan_busy_out(chb), .busy_out(busy),
    .complete_out(cmpl), .error_out(err));
  mrh_link_model i_link (.clk_sys_in(clk_sys_in), .start_in(start), .count_in(cnt),
    .slow_in(slow), .rx_ready_in(ready), .rx_valid_out(rv), .rx_data_out(rxd),
    .rx_last_out(rl));
  initial forever #50 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) resp_cnt <= resp_cnt + resp;
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_in);
    wr <= w; rd <= !w; adr <= a; wd <= d;
    k = 0;
    do begin @(posedge clk_sys_in); k++; end while (wait_n !== 1'b0 && k < 50);
    q = rdat;
    wr <= 1'b0; rd <= 1'b0;
    if (k >= 50) begin num_errors++; print_verdict(); end
  endtask : bus
  task automatic tick(input logic [1:0] c); // scan with control bits
    bus(1, 8'h00, {30'h0, c});
    bus(1, 8'h18, 32'h0000_0001);
  endtask : tick
  task automatic stat(input logic [2:0] e);
    bus(0, 8'h14, 0); chk("status", q[2:0], e);
    chk("flags", {err, cmpl, busy}, e);
  endtask : stat
  function automatic int digit(int d, int p, int c, int h);
    int cm, hm;
    cm = 8; hm = 10;
    if (d == 5) begin cm = 16; hm = 1; end
    else if (d == 1) hm = 12;
    else if (d != 6 && d != 16) return 1;
    if (p < 1 || p > 3) return 2;
    if (c < 1 || c > cm) return 3;
    if (h < 1 || h > hm) return 4;
    return 0;
  endfunction : digit
  task automatic run(input int d, input int p, input int c, input int h);
    int y, n, r0, k;
    y = digit(d, p, c, h);
    n = $urandom_range(1, 8);
    slow <= 1'($urandom);
    sb <= (d == 5 && y == 0);
    bus(1, 8'h04, d); bus(1, 8'h08, p); bus(1, 8'h0C, c); bus(1, 8'h10, h);
    tick(2'b00); tick(2'b01); r0 = resp_cnt;
    if (y != 0) begin
      stat(3'b100); chk("ready", ready, 0);
      chk("digit", q[7:4], y);
      bus(0, 8'h40, 0); chk("result", q[15:0], 16'h8000 | y << 8);
    end else begin
      stat(3'b001); bus(0, 8'h40, 0); chk("result", q[15:0], 16'h0000);
      if (d == 5) begin chk("ready", ready, 0); sb <= 1'b0; tick(2'b01); end
      chk("chan", chb, d == 5);
      cnt <= n; start <= 1'b1; @(posedge clk_sys_in); start <= 1'b0;
      k = 0;
      do begin @(posedge clk_sys_in); k++; end while ((ready !== 1'b0 || k < 3) && k < 200);
      if (k >= 200) begin num_errors++; print_verdict(); end
      stat(3'b001); tick(2'b01); stat(3'b010);
      bus(0, 8'h40, 0); chk("result", q[15:0], 16'h1000);
      bus(0, 8'h58, 0); chk("size", q[15:0], p == 3 ? 2 * n : n);
      chk("resp", resp_cnt - r0, p == 1);
    end
    tick(2'b00); stat(3'b000);
  endtask : run
  initial begin
    void'($urandom(32'habf4_d08e));
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    stat(3'b000);
    bus(0, 8'h30, 0); chk("unmapped", q[15:0], 0);
    bus(1, 8'h80, 32'h0000_5A5A); bus(0, 8'h80, 0); chk("word16", q[15:0], 16'h5A5A);
    run(5, 3, 16, 1); run(1, 1, 8, 12); run(16, 2, 1, 10); run(6, 1, 8, 10);
    run(2, 1, 1, 1); run(5, 4, 1, 1); run(6, 1, 9, 1); run(5, 1, 1, 2);
    run(1, 1, 0, 1); run(1, 1, 1, 13); run(16, 2, 1, 11); run(5, 3, 17, 1);
    bus(1, 8'h0C, 32'h0000_0001);
    tick(2'b01); stat(3'b001); tick(2'b11); stat(3'b001);
    tick(2'b11); stat(3'b010); chk("ready", ready, 0);
    tick(2'b00); tick(2'b11); chk("ready", ready, 0); stat(3'b001);
    tick(2'b11); stat(3'b010); bus(0, 8'h40, 0); chk("result", q[15:0], 16'h1000);
    print_verdict();
  end
endmodule : mrh_top_tb_top
